// file: logic/esct_core.sv
/*
  Event state timer core with APB register access.
  Assumes pclk at 100 MHz, asynchronous event inputs, and an APB master.
*/
`default_nettype none
// Function
// - A halt-action event halts its selected counter.
// - A halted counter suppresses its events until software restarts it.
// - An event assigned to a DMA request pulses that request.
// - Count writes take effect only while that counter's halt bit is 1.
// - Count writes while running set the low or high bus-error flag.
// - Count registers read the current count at any time.
// - Each event has a readable, writable per-state enable mask.
// - Capture-enabled events load their capture register with the count.
// - Counter runs as two 16-bit halves or one 32-bit joined counter.
// - Joined mode ignores the high half's halt, writes and event select; each counter has direction and prescaler.
// - Eight event inputs, 0 to 7, serve as event conditions.
// - Ten outputs, 0 to 9, are set, cleared or toggled by events.
// - Clock source: system, sampled system, input pin, or asynchronous.
// - In input clock mode, count on a chosen edge of input 0..7.
// - Simultaneous set and clear apply the output's resolution choice.
// - In up-down mode events fire on any, up-only or down-only direction.
// - PWM may be edge-aligned or center-aligned.
// - PWM pulses may be active high, active low, or absent.
module esct_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [esct_pkg::N_IN-1:0]  ev_in,
  output logic      [esct_pkg::N_OUT-1:0] out_pin,
  output logic      [esct_pkg::N_DMA-1:0] dma_req
);
  import esct_pkg::*;

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic io_hit(logic [1:0] c, logic f, logic fd);
    unique case (esct_ioc_t'(c))
      IO_LOW:  io_hit = ~f;
      IO_RISE: io_hit = f & ~fd;
      IO_FALL: io_hit = ~f & fd;
      IO_HIGH: io_hit = f;
    endcase
  endfunction : io_hit

  // Returns {down, count}; limit reverses in up-down mode (center PWM)
  function automatic logic [32:0] step(logic [31:0] c, logic [31:0] mx,
                                       logic dn, logic ud, logic lim, logic tk);
    step = {dn, c};
    if (lim)
      step = ud ? {1'b1, c - 32'h1} : {dn, 32'h0};
    else if (tk && dn)
      step = (c == 32'h0) ? {1'b0, c + 32'h1} : {1'b1, c - 32'h1};
    else if (tk && c == mx)
      step = ud ? {1'b1, c - 32'h1} : {1'b0, 32'h0};
    else if (tk)
      step = {1'b0, c + 32'h1};
  endfunction : step

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  logic [N_IN-1:0]  in_s1, in_s2, in_s3, in_f, in_fd;
  logic [N_IN-1:0]  next_in_f;
  logic [31:0]      cfg, ctrl, next_cfg, next_ctrl;
  logic [15:0]      cnt_l, cnt_h, next_cnt_l, next_cnt_h;
  logic [7:0]       pre_l, pre_h, next_pre_l, next_pre_h;
  logic             dir_l, dir_h, next_dir_l, next_dir_h;
  logic [4:0]       state, next_state;
  logic [N_OUT-1:0] outv, next_outv;
  logic [19:0]      res, next_res;
  logic [1:0]       err, next_err;
  logic [N_DMA-1:0] next_dma;
  logic [15:0]      ev_ctrl [N_EV];
  logic [31:0]      ev_mask [N_EV];
  logic [31:0]      ev_mtch [N_EV];
  logic [31:0]      ev_outs [N_EV];
  logic [31:0]      cap     [N_EV];
  logic [15:0]      next_ev_ctrl [N_EV];
  logic [31:0]      next_ev_mask [N_EV];
  logic [31:0]      next_ev_mtch [N_EV];
  logic [31:0]      next_ev_outs [N_EV];
  logic [31:0]      next_cap     [N_EV];
  logic [31:0]      next_prdata;
  logic             next_pslverr;

  // --------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------
  // A level is accepted once stages two and three agree
  always_comb
  begin
    next_in_f = (in_s2 & in_s3) | (in_f & (in_s2 ^ in_s3));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_s1 <= '0;
      in_s2 <= '0;
      in_s3 <= '0;
      in_f  <= '0;
      in_fd <= '0;
    end
    else
    begin
      in_s1 <= ev_in;
      in_s2 <= in_s1;
      in_s3 <= in_s2;
      in_f  <= next_in_f;
      in_fd <= in_f;
    end
  end

  // --------------------------------------------------------------
  // Counter clocking
  // --------------------------------------------------------------
  logic       join_m, ud_l, ud_h, halt_l, halt_h, clk_ok, tick_l, tick_h;
  logic [2:0] csel;
  assign join_m = cfg[CFG_JOIN];
  assign ud_l   = cfg[CFG_UD_L];
  assign ud_h   = cfg[CFG_UD_H] & ~join_m;
  assign halt_l = ctrl[CTL_HLT_L];
  assign halt_h = ctrl[CTL_HLT_H] | join_m;
  assign csel   = cfg[CFG_CLKS+1 +: 3];

  // Asynchronous mode is also resolved on pclk; both pin modes count edges
  always_comb
  begin
    unique case (esct_clkm_t'(cfg[CFG_CLKM +: 2]))
      CLK_SYS, CLK_SAMPLED: clk_ok = 1'b1;
      CLK_INPUT, CLK_ASYNC:
        clk_ok = io_hit(cfg[CFG_CLKS] ? IO_FALL : IO_RISE,
                        in_f[csel], in_fd[csel]);
    endcase
    tick_l = ~halt_l & clk_ok & (pre_l == ctrl[CTL_PRE_L +: 8]);
    tick_h = ~halt_h & clk_ok & (pre_h == ctrl[CTL_PRE_H +: 8]);
  end

  // --------------------------------------------------------------
  // Event decode
  // --------------------------------------------------------------
  logic [N_EV-1:0] ev_fire, ev_hsel;
  logic [31:0]     ev_cval [N_EV];

  always_comb
  begin
    logic        hs, mt, io, cm, dn, ud, dok;
    logic [15:0] c;
    logic [31:0] mv;
    hs = 1'b0; mt = 1'b0; io = 1'b0; cm = 1'b0;
    dn = 1'b0; ud = 1'b0; dok = 1'b0; c = '0; mv = '0;
    for (int e = 0; e < N_EV; e++)
    begin
      c  = ev_ctrl[e];
      hs = c[EVC_HEV] & ~join_m;
      ev_cval[e] = join_m ? {cnt_h, cnt_l} : hs ? {16'h0, cnt_h} : {16'h0, cnt_l};
      mv = join_m ? ev_mtch[e] : {16'h0, ev_mtch[e][15:0]};
      mt = (hs ? tick_h : tick_l) & (ev_cval[e] == mv);
      io = io_hit(c[EVC_IOC +: 2], in_f[c[EVC_INS +: 3]], in_fd[c[EVC_INS +: 3]]);
      unique case (esct_cmb_t'(c[EVC_CMB +: 2]))
        CMB_OR:    cm = mt | io;
        CMB_MATCH: cm = mt;
        CMB_IO:    cm = io;
        CMB_AND:   cm = mt & io;
      endcase
      dn = hs ? dir_h : dir_l;
      ud = hs ? ud_h : ud_l;
      unique case (c[EVC_DIR +: 2])
        DIR_UP:   dok = ~ud | ~dn;
        DIR_DOWN: dok = ~ud | dn;
        default:  dok = 1'b1;
      endcase
      ev_fire[e] = ~(hs ? halt_h : halt_l) & ev_mask[e][state] & cm & dok;
      ev_hsel[e] = hs;
    end
  end

  // --------------------------------------------------------------
  // Register file and counter next state
  // --------------------------------------------------------------
  logic        wr, rd_setup;
  logic [2:0]  ei;
  logic [1:0]  eo;
  logic        is_ev, is_cap;
  assign wr       = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign ei       = paddr[6:4];
  assign eo       = paddr[3:2];
  assign is_ev    = paddr[11:8] == EV_PAGE && !paddr[7];
  assign is_cap   = paddr[11:5] == CAP_PAGE;

  always_comb
  begin
    logic             hl, hh, ll, lh, s, cl;
    logic [32:0]      sl, sh;
    logic [N_OUT-1:0] ts, tc;
    hl = 1'b0; hh = 1'b0; ll = 1'b0; lh = 1'b0; s = 1'b0; cl = 1'b0;
    sl = '0; sh = '0; ts = '0; tc = '0;
    next_cfg = cfg; next_ctrl = ctrl; next_state = state; next_outv = outv;
    next_res = res; next_err = err; next_dma = '0;
    next_ev_ctrl = ev_ctrl; next_ev_mask = ev_mask;
    next_ev_mtch = ev_mtch; next_ev_outs = ev_outs; next_cap = cap;
    // Event actions
    for (int e = 0; e < N_EV; e++)
    begin
      if (ev_fire[e])
      begin
        hl |= ev_ctrl[e][EVC_HALT] & ~ev_hsel[e];
        hh |= ev_ctrl[e][EVC_HALT] & ev_hsel[e];
        ll |= ev_ctrl[e][EVC_LIM] & ~ev_hsel[e];
        lh |= ev_ctrl[e][EVC_LIM] & ev_hsel[e];
        next_dma |= ev_ctrl[e][EVC_DMA +: N_DMA];
        ts |= ev_outs[e][N_OUT-1:0];
        tc |= ev_outs[e][EVO_CLR +: N_OUT];
        if (ev_ctrl[e][EVC_CAP])
          next_cap[e] = ev_cval[e];
      end
    end
    // Counters; joined mode steps the whole 32-bit value in the low path
    sl = step(join_m ? {cnt_h, cnt_l} : {16'h0, cnt_l},
              join_m ? 32'hffff_ffff : 32'h0000_ffff, dir_l, ud_l, ll, tick_l);
    sh = step({16'h0, cnt_h}, 32'h0000_ffff, dir_h, ud_h, lh, tick_h);
    next_dir_l = sl[32];
    next_cnt_l = sl[15:0];
    next_dir_h = join_m ? sl[32] : sh[32];
    next_cnt_h = join_m ? sl[31:16] : sh[15:0];
    next_pre_l = (tick_l | ll) ? 8'h0 : (~halt_l & clk_ok) ? pre_l + 8'h1 : pre_l;
    next_pre_h = (tick_h | lh) ? 8'h0 : (~halt_h & clk_ok) ? pre_h + 8'h1 : pre_h;
    // Software writes
    if (wr)
    begin
      unique case (paddr)
        A_CFG:   next_cfg = {23'h0, pwdata[8:0]};
        A_CTRL:  next_ctrl = pwdata & CTRL_MSK;
        A_CNT_L:
          if (halt_l)
          begin
            next_cnt_l = pwdata[15:0];
            if (join_m)
              next_cnt_h = pwdata[31:16];
          end
          else
            next_err[0] = 1'b1;
        A_CNT_H:
          if (halt_h && !join_m)
            next_cnt_h = pwdata[15:0];
          else if (!join_m)
            next_err[1] = 1'b1;
        A_STATE: next_state = pwdata[4:0];
        A_OUT:   next_outv = pwdata[N_OUT-1:0];
        A_RES:   next_res = pwdata[19:0];
        A_ERR:   next_err = err & ~pwdata[1:0];
        default:
          if (is_ev)
          begin
            unique case (eo)
              EV_CTRL: next_ev_ctrl[ei] = pwdata[15:0];
              EV_MASK: next_ev_mask[ei] = pwdata;
              EV_MTCH: next_ev_mtch[ei] = pwdata;
              EV_OUTS: next_ev_outs[ei] = pwdata & 32'h03ff_03ff;
            endcase
          end
      endcase
    end
    // Hardware halt wins over a software restart in the same cycle
    next_ctrl[CTL_HLT_L] = next_ctrl[CTL_HLT_L] | hl;
    next_ctrl[CTL_HLT_H] = next_ctrl[CTL_HLT_H] | hh;
    // Outputs: events take precedence over a software write
    for (int o = 0; o < N_OUT; o++)
    begin
      s  = ts[o];
      cl = tc[o];
      if (s && cl)
      begin
        unique case (esct_res_t'(res[2*o +: 2]))
          RES_NONE: next_outv[o] = outv[o];
          RES_SET:  next_outv[o] = 1'b1;
          RES_CLR:  next_outv[o] = 1'b0;
          RES_TOG:  next_outv[o] = ~outv[o];
        endcase
      end
      else if (s)
        next_outv[o] = 1'b1;
      else if (cl)
        next_outv[o] = 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Read path, sampled in the setup phase
  // --------------------------------------------------------------
  always_comb
  begin
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (rd_setup)
    begin
      next_pslverr = 1'b0;
      next_prdata  = 32'h0;
      unique case (paddr)
        A_CFG:   next_prdata = cfg;
        A_CTRL:  next_prdata = ctrl;
        A_CNT_L: next_prdata = join_m ? {cnt_h, cnt_l} : {16'h0, cnt_l};
        A_CNT_H: next_prdata = {16'h0, cnt_h};
        A_STATE: next_prdata = {27'h0, state};
        A_OUT:   next_prdata = {22'h0, outv};
        A_RES:   next_prdata = {12'h0, res};
        A_ERR:   next_prdata = {30'h0, err};
        default:
          if (is_ev)
          begin
            unique case (eo)
              EV_CTRL: next_prdata = {16'h0, ev_ctrl[ei]};
              EV_MASK: next_prdata = ev_mask[ei];
              EV_MTCH: next_prdata = ev_mtch[ei];
              EV_OUTS: next_prdata = ev_outs[ei];
            endcase
          end
          else if (is_cap)
            next_prdata = cap[paddr[4:2]];
          else
            next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg <= '0; ctrl <= CTRL_RST; cnt_l <= '0; cnt_h <= '0;
      pre_l <= '0; pre_h <= '0; dir_l <= 1'b0; dir_h <= 1'b0;
      state <= '0; outv <= '0; res <= '0; err <= '0; dma_req <= '0;
      prdata <= '0; pslverr <= 1'b0;
      for (int e = 0; e < N_EV; e++)
      begin
        ev_ctrl[e] <= '0; ev_mask[e] <= '0; ev_mtch[e] <= '0;
        ev_outs[e] <= '0; cap[e] <= '0;
      end
    end
    else
    begin
      cfg <= next_cfg; ctrl <= next_ctrl; cnt_l <= next_cnt_l; cnt_h <= next_cnt_h;
      pre_l <= next_pre_l; pre_h <= next_pre_h; dir_l <= next_dir_l;
      dir_h <= next_dir_h; state <= next_state; outv <= next_outv;
      res <= next_res; err <= next_err; dma_req <= next_dma;
      prdata <= next_prdata; pslverr <= next_pslverr;
      ev_ctrl <= next_ev_ctrl; ev_mask <= next_ev_mask; ev_mtch <= next_ev_mtch;
      ev_outs <= next_ev_outs; cap <= next_cap;
    end
  end

  assign pready  = 1'b1;
  assign out_pin = outv;
endmodule : esct_core
`default_nettype wire

// file: logic/esct_pkg.sv
/*
  Constants for the event state timer core: register map, field
  positions, reset values and encodings. Assumes a 12-bit APB byte address.
*/
`default_nettype none
package esct_pkg;
  localparam int N_EV  = 8;
  localparam int N_IN  = 8;
  localparam int N_OUT = 10;
  localparam int N_DMA = 2;
  // --------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------
  localparam logic [11:0] A_CFG   = 12'h000;
  localparam logic [11:0] A_CTRL  = 12'h004;
  localparam logic [11:0] A_CNT_L = 12'h008;
  localparam logic [11:0] A_CNT_H = 12'h00c;
  localparam logic [11:0] A_STATE = 12'h010;
  localparam logic [11:0] A_OUT   = 12'h014;
  localparam logic [11:0] A_RES   = 12'h018;
  localparam logic [11:0] A_ERR   = 12'h01c;
  localparam logic [3:0]  EV_PAGE = 4'h1;
  localparam logic [6:0]  CAP_PAGE = 7'h10;
  localparam logic [1:0]  EV_CTRL = 2'h0;
  localparam logic [1:0]  EV_MASK = 2'h1;
  localparam logic [1:0]  EV_MTCH = 2'h2;
  localparam logic [1:0]  EV_OUTS = 2'h3;
  // --------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------
  localparam int CFG_JOIN = 0;
  localparam int CFG_CLKM = 1;
  localparam int CFG_CLKS = 3;
  localparam int CFG_UD_L = 7;
  localparam int CFG_UD_H = 8;
  localparam int CTL_HLT_L = 0;
  localparam int CTL_HLT_H = 1;
  localparam int CTL_PRE_L = 2;
  localparam int CTL_PRE_H = 10;
  localparam int EVC_INS  = 0;
  localparam int EVC_IOC  = 3;
  localparam int EVC_CMB  = 5;
  localparam int EVC_HEV  = 7;
  localparam int EVC_DIR  = 8;
  localparam int EVC_HALT = 10;
  localparam int EVC_LIM  = 11;
  localparam int EVC_DMA  = 12;
  localparam int EVC_CAP  = 14;
  localparam int EVO_CLR  = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0003;
  localparam logic [31:0] CTRL_MSK = 32'h0003_ffff;
  // --------------------------------------------------------------
  // Encodings
  // --------------------------------------------------------------
  typedef enum logic [1:0] {CLK_SYS, CLK_SAMPLED, CLK_INPUT, CLK_ASYNC} esct_clkm_t;
  typedef enum logic [1:0] {IO_LOW, IO_RISE, IO_FALL, IO_HIGH} esct_ioc_t;
  typedef enum logic [1:0] {CMB_OR, CMB_MATCH, CMB_IO, CMB_AND} esct_cmb_t;
  typedef enum logic [1:0] {RES_NONE, RES_SET, RES_CLR, RES_TOG} esct_res_t;
  typedef enum logic [1:0] {DIR_ANY, DIR_UP, DIR_DOWN} esct_dir_t;
endpackage : esct_pkg
`default_nettype wire

// file: tb/esct_monitor.sv
/*
  Port checker for esct_core: APB read timing and register read widths.
  Assumes APB with no wait states; bound to every esct_core instance.
*/
`default_nettype none
module esct_monitor
  import esct_pkg::*;
(
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [N_IN-1:0]  ev_in,
  input wire logic [N_OUT-1:0] out_pin,
  input wire logic [N_DMA-1:0] dma_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // Transfer phases
  // ------------------------------------------------------------
  sequence setup_s(logic [11:0] a);
    psel && !penable && paddr == a;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  ready_access_a: assert property (access_s |-> pready)
    else $error("pready low in an access cycle");
  read_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("prdata moved outside a setup cycle");
  cnt_read_a: assert property (setup_s(A_CNT_L) |=> !pslverr)
    else $error("count read refused");
  hole_err_a: assert property (setup_s(12'hffc) |=> pslverr)
    else $error("unmapped read not refused");
  ctrl_width_a: assert property (setup_s(A_CTRL) |=> (prdata & ~CTRL_MSK) == 32'h0)
    else $error("control read has stray bits");
  err_width_a: assert property (setup_s(A_ERR) |=> prdata[31:2] == 30'h0)
    else $error("error read has stray bits");
  state_width_a: assert property (setup_s(A_STATE) |=> prdata[31:5] == 27'h0)
    else $error("state read has stray bits");
  cfg_width_a: assert property (setup_s(A_CFG) |=> prdata[31:9] == 23'h0)
    else $error("config read has stray bits");
  out_mirror_a: assert property (setup_s(A_OUT) |=> prdata == {22'h0, $past(out_pin)})
    else $error("output read differs from output pins");
  res_width_a: assert property (setup_s(A_RES) |=> prdata[31:20] == 12'h0)
    else $error("resolution read has stray bits");
endmodule : esct_monitor
bind esct_core esct_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ev_in(ev_in), .out_pin(out_pin),
  .dma_req(dma_req));
`default_nettype wire

// file: tb/esct_pins_model.sv
/*
  Model of the pins around esct_core: event input drivers and a DMA
  controller that counts request pulses. Assumes the bench calls pulse.
*/
`default_nettype none
module esct_pins_model
  import esct_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic [N_DMA-1:0] dma_req,
  output logic      [N_IN-1:0]  ev_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int dma_cnt [N_DMA] = '{default: 0};
  initial ev_in = '0;
  // Six cycles per level so the four-edge input filter always settles
  task automatic pulse(input int idx, input int n);
    repeat (n)
    begin
      ev_in[idx] <= 1'b1;
      repeat (6) @(posedge pclk);
      ev_in[idx] <= 1'b0;
      repeat (6) @(posedge pclk);
    end
  endtask : pulse
  always @(posedge pclk)
    for (int i = 0; i < N_DMA; i++)
      if (dma_req[i] === 1'b1)
        dma_cnt[i] <= dma_cnt[i] + 1;
endmodule : esct_pins_model
`default_nettype wire

// file: tb/esct_core_bench.sv
/*
  Self-checking bench for esct_core: APB register tasks and event scenarios.
  Assumes the pin model in esct_pins_model.sv and the bound port checker.
*/
`default_nettype none
module esct_core_bench import esct_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic             pclk;
  logic             presetn;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [11:0]      paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [N_IN-1:0]  ev_in;
  logic [N_OUT-1:0] out_pin;
  logic [N_DMA-1:0] dma_req;
  logic             last_err;
  logic [31:0]      v1;
  logic [31:0]      v2;
  int               mismatches;
  int               n_compared;
  esct_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ev_in(ev_in), .out_pin(out_pin), .dma_req(dma_req));
  esct_pins_model pins (.pclk(pclk), .dma_req(dma_req), .ev_in(ev_in));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Entered just after a rising edge; leaves one idle cycle behind it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 50)
    begin
      mismatches++;
      final_report();
    end
  endtask : apb
  task automatic w(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : w
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : rchk
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mismatches = 0;
    n_compared = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(A_CTRL, CTRL_RST);
    rchk(A_STATE, 32'h0);
    w(A_CNT_L, 32'h0000_1234);
    rchk(A_CNT_L, 32'h0000_1234);
    w(A_CTRL, 32'h0000_0002);
    w(A_CNT_L, 32'h0000_5555);
    rchk(A_ERR, 32'h0000_0001);
    apb(1'b0, A_CNT_L, 32'h0, v1);
    apb(1'b0, A_CNT_L, 32'h0, v2);
    check(v2 - v1, 32'h3);
    w(A_ERR, 32'h0000_0001);
    rchk(A_ERR, 32'h0);
    w(A_CNT_H, 32'h0000_00ab);
    rchk(A_CNT_H, 32'h0000_00ab);
    apb(1'b0, 12'hffc, 32'h0, v1);
    check({31'h0, last_err}, 32'h1);
    // Event 0: rise of input 0 halts L, asks DMA 0, captures, drives outputs
    w(A_OUT, 32'h0000_0005);
    w(A_RES, 32'h0000_00e4);
    rchk(A_RES, 32'h0000_00e4);
    w(12'h100, 32'h0000_5448);
    w(12'h10c, 32'h000f_020f);
    pins.pulse(0, 1);
    check({22'h0, out_pin}, 32'h0000_0005);
    w(12'h104, 32'h0000_0001);
    rchk(12'h104, 32'h0000_0001);
    pins.pulse(0, 1);
    check({22'h0, out_pin}, 32'h0000_020b);
    check(pins.dma_cnt[0], 32'h1);
    check(pins.dma_cnt[1], 32'h0);
    rchk(A_CTRL, 32'h0000_0003);
    rchk(A_OUT, 32'h0000_020b);
    apb(1'b0, 12'h200, 32'h0, v1);
    apb(1'b0, A_CNT_L, 32'h0, v2);
    check({31'h0, (v2 - v1) <= 32'h1}, 32'h1);
    rchk(A_CNT_L, v2);
    pins.pulse(0, 1);
    check({22'h0, out_pin}, 32'h0000_020b);
    check(pins.dma_cnt[0], 32'h1);
    // Every clock source; pin modes count five edges of input 3
    for (int m = 0; m < 4; m++)
    begin
      w(A_CTRL, 32'h0000_0003);
      w(A_CFG, {25'h0, 3'd3, m[0], m[1:0], 1'b0});
      rchk(A_CFG, {25'h0, 3'd3, m[0], m[1:0], 1'b0});
      w(A_CNT_L, 32'h0);
      w(A_CTRL, 32'h0000_0002);
      if (m < 2)
      begin
        apb(1'b0, A_CNT_L, 32'h0, v1);
        apb(1'b0, A_CNT_L, 32'h0, v2);
        check(v2 - v1, 32'h3);
      end
      else
      begin
        pins.pulse(3, 5);
        rchk(A_CNT_L, 32'h5);
      end
    end
    // Joined counter carries past sixteen bits
    w(A_CTRL, 32'h0000_0003);
    w(A_CFG, 32'h0000_0001);
    w(A_CNT_L, 32'h1234_ffff);
    w(A_CNT_H, 32'h0000_0077);
    rchk(A_CNT_L, 32'h1234_ffff);
    rchk(A_ERR, 32'h0);
    w(A_CTRL, 32'h0);
    apb(1'b0, A_CNT_L, 32'h0, v2);
    check({16'h0, v2[31:16]}, 32'h0000_1235);
    // Event 1: H match at 4 limits H, asks DMA 1 and captures; enabled in state 1 only
    w(A_CTRL, 32'h0000_0003);
    w(A_CFG, 32'h0);
    w(A_CNT_H, 32'h0);
    w(12'h110, 32'h0000_68a0);
    w(12'h114, 32'h0000_0002);
    w(12'h118, 32'h0000_0004);
    w(A_CTRL, 32'h0000_0401);
    repeat (30) @(posedge pclk);
    check(pins.dma_cnt[1], 32'h0);
    w(A_CTRL, 32'h0000_0003);
    w(A_CNT_H, 32'h0);
    w(A_STATE, 32'h1);
    w(A_CTRL, 32'h0000_0401);
    repeat (30) @(posedge pclk);
    check({31'h0, pins.dma_cnt[1] > 0}, 32'h1);
    rchk(12'h204, 32'h4);
    apb(1'b0, A_CNT_H, 32'h0, v1);
    check({31'h0, v1 <= 32'h4}, 32'h1);
    check(pins.dma_cnt[0], 32'h1);
    final_report();
  end
endmodule : esct_core_bench
`default_nettype wire
